/* File: verilog/sis_pkg.sv */
// Purpose: Shared constants for the step interpolator with standstill detection
// Assumes: One system clock, synchronous active-low reset
// Notes: Counts are in system clock cycles
package sis_pkg;

  // Period measurement and microstep spacing
  localparam int PER_W = 21;
  localparam logic [20:0] PER_LIMIT = 21'h100000;
  localparam int INT_W = 17;
  localparam logic [16:0] INT_MAX = 17'h10000;
  localparam logic [16:0] INT_MIN = 17'h00001;

  // Burst length and resolution codes
  localparam logic [4:0] BURST_LEN = 5'h10;
  localparam logic [3:0] RES_16X = 4'h4;
  localparam logic [3:0] RES_FULL = 4'h8;

  // Microstep counter reset value and unit step, current level width
  localparam logic [9:0] MSCNT_RST = 10'h000;
  localparam logic [9:0] MSCNT_ONE = 10'h001;
  localparam int CUR_W = 5;

endpackage : sis_pkg

/* File: verilog/sis_sync_if.sv */
// Purpose: Carrier between the top and its input synchroniser
// Assumes: Raw pins come from outside the clock domain
// Notes: Width is set per instance
`timescale 1ns/1ps
interface sis_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync
  (
    input raw,
    output synced
  );
  modport user
  (
    output raw,
    input synced
  );
endinterface : sis_sync_if

/* File: verilog/sis_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Pins settle between samples
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module sis_sync2
  import sis_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins in, synchronised levels out
  sis_sync_if.sync p
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  // Next values of both stages
  always_comb
  begin
    next_stage1 = p.raw;
    next_stage2 = stage1;
    if (!rstn)
    begin
      next_stage1 = '0;
      next_stage2 = '0;
    end
  end

  // Stage registers
  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    stage2 <= next_stage2;
  end

  assign p.synced = stage2;

endmodule : sis_sync2

/* File: verilog/sis_interp.sv */
// Purpose: Step/direction input with 16x to 256x microstep interpolation and standstill detection
// Assumes: Configuration bits are plain inputs held stable by the controller
// Notes: Step, direction and clock-pin levels are synchronised before use
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// R01: Each active step edge in interpolation mode starts a burst of 16 microsteps
// R02: Interpolation needs enable bit and 16x resolution
// R03: Spacing is previous step period over 16
// R04: Period capped at 2^20, spacing 2^16
// R05: Too slow stepping sets the standstill flag
// R06: Standstill selects hold current, else run current
// R07: Next active step edge clears standstill
// R08: New rate used after one full period
// R09: New edge abandons rest of running burst
// R10: Controller keeps rate stable, dedge needs 50%
// R11: Internal oscillator while clock pin stays low
// R12: First high on clock pin selects external
// R13: Controller disables drivers before stopping clock
// R14: Short detection works without any clock
// R15: Reset loads defaults into all state
// R16: Double-edge bit makes both step edges active
// R17: Direction low counts up, high counts down
// R18: Microsteps move one entry in latched direction
module sis_interp
  import sis_pkg::*;
#(
  parameter logic [PER_W-1:0] PERIOD_LIMIT = PER_LIMIT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Step/direction pins and clock pin level
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic clk_pin,
  // Configuration
  input wire logic interp_enable,
  input wire logic dedge,
  input wire logic [3:0] resolution_select,
  input wire logic [CUR_W-1:0] run_current_level,
  input wire logic [CUR_W-1:0] hold_current_level,
  // Short-to-ground detection
  input wire logic short_detect_enable,
  input wire logic short_detect_raw,
  output logic short_detect_flag,
  // Status and results
  output logic [9:0] microstep_count,
  output logic microstep_pulse,
  output logic standstill,
  output logic [CUR_W-1:0] current_level,
  output logic interp_active,
  output logic clock_ext_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  sis_sync_if #(.W(3)) pins ();
  assign pins.raw = {clk_pin, dir_pin, step_pin};

  sis_sync2 #(.W(3)) u_sync
  (
    .clk(clk),
    .rstn(rstn),
    .p(pins.sync)
  );

  logic step_s;
  logic dir_s;
  logic clkpin_s;
  assign step_s = pins.synced[0];
  assign dir_s = pins.synced[1];
  assign clkpin_s = pins.synced[2];

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic step_d;
  logic [PER_W-1:0] per_cnt;
  logic [INT_W-1:0] interval;
  logic [INT_W-1:0] tick;
  logic [4:0] burst_left;
  logic burst_dir;
  logic [PER_W-1:0] next_per_cnt;
  logic [INT_W-1:0] next_interval;
  logic [INT_W-1:0] next_tick;
  logic [4:0] next_burst_left;
  logic next_burst_dir;
  logic next_step_d;
  logic [9:0] next_microstep_count;
  logic next_microstep_pulse;
  logic next_standstill;
  logic next_clock_ext_sel;

  logic step_edge;
  logic interp_mode;
  logic stst_set;
  logic [3:0] res_clamped;
  logic [9:0] step_width;

  // Active edge and mode decode
  always_comb
  begin
    if (dedge)
      step_edge = step_s ^ step_d; // R16
    else
      step_edge = step_s & ~step_d; // R16
    interp_mode = interp_enable && (resolution_select == RES_16X); // R02
    stst_set = (per_cnt == PERIOD_LIMIT - 21'h1) && !step_edge; // R05
    res_clamped = (resolution_select > RES_FULL) ? RES_FULL : resolution_select;
    step_width = MSCNT_ONE << res_clamped;
  end

  // Next values of the interpolator
  always_comb
  begin
    next_step_d = step_s;
    next_per_cnt = per_cnt;
    next_interval = interval;
    next_tick = tick;
    next_burst_left = burst_left;
    next_burst_dir = burst_dir;
    next_microstep_count = microstep_count;
    next_microstep_pulse = 1'b0;
    next_standstill = standstill;
    next_clock_ext_sel = clock_ext_sel | clkpin_s; // R11 R12
    // Period measurement, saturating at the limit
    if (per_cnt != PERIOD_LIMIT)
      next_per_cnt = per_cnt + 21'h1; // R04
    if (step_edge)
    begin
      next_per_cnt = '0;
      next_standstill = 1'b0; // R07
      // Spacing from the period just ended
      if (per_cnt[PER_W-1:4] == '0)
        next_interval = INT_MIN;
      else
        next_interval = per_cnt[PER_W-1:4]; // R03 R04 R08
      if (interp_mode)
      begin
        // First microstep at once, restart burst
        next_burst_left = BURST_LEN - 5'h1; // R01 R09
        next_burst_dir = dir_s;
        next_tick = '0;
        next_microstep_pulse = 1'b1;
        next_microstep_count = dir_s ? microstep_count - MSCNT_ONE : microstep_count + MSCNT_ONE; // R18
      end
      else
      begin
        next_burst_left = '0;
        next_microstep_pulse = 1'b1;
        next_microstep_count = dir_s ? microstep_count - step_width : microstep_count + step_width; // R17
      end
    end
    else if (burst_left != '0)
    begin
      // Evenly spaced remaining microsteps
      if (tick >= interval - INT_MIN)
      begin
        next_tick = '0;
        next_burst_left = burst_left - 5'h1; // R01
        next_microstep_pulse = 1'b1;
        next_microstep_count = burst_dir ? microstep_count - MSCNT_ONE : microstep_count + MSCNT_ONE; // R18
      end
      else
        next_tick = tick + INT_MIN; // R03
    end
    if (stst_set)
      next_standstill = 1'b1; // R05
    if (!rstn)
    begin
      // Power-on defaults
      next_step_d = 1'b0; // R15
      next_per_cnt = '0;
      next_interval = INT_MAX;
      next_tick = '0;
      next_burst_left = '0;
      next_burst_dir = 1'b0;
      next_microstep_count = MSCNT_RST;
      next_microstep_pulse = 1'b0;
      next_standstill = 1'b0;
      next_clock_ext_sel = 1'b0;
    end
  end

  // Interpolator registers
  always_ff @(posedge clk)
  begin
    step_d <= next_step_d;
    per_cnt <= next_per_cnt;
    interval <= next_interval;
    tick <= next_tick;
    burst_left <= next_burst_left;
    burst_dir <= next_burst_dir;
    microstep_count <= next_microstep_count;
    microstep_pulse <= next_microstep_pulse;
    standstill <= next_standstill;
    clock_ext_sel <= next_clock_ext_sel;
  end

  // Current selection and status
  assign current_level = standstill ? hold_current_level : run_current_level; // R06
  assign interp_active = burst_left != '0;
  // Clock-free short detection path
  assign short_detect_flag = short_detect_enable & short_detect_raw; // R14

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [4:0] burst_seen;
  logic [4:0] next_burst_seen;

  // Microsteps counted since the last active step edge
  always_comb
  begin
    next_burst_seen = burst_seen;
    if (step_edge)
      next_burst_seen = 5'h0;
    else if (microstep_pulse && burst_seen != 5'h1f)
      next_burst_seen = burst_seen + 5'h1;
    if (!rstn)
      next_burst_seen = 5'h0;
  end

  always_ff @(posedge clk)
  begin
    burst_seen <= next_burst_seen;
  end

  a_burst_start: assert property (@(posedge clk) disable iff (!rstn) // R01
    step_edge && interp_mode |=> microstep_pulse && burst_left == 5'hf)
    else $error("burst did not start on step edge");

  a_burst_bound: assert property (@(posedge clk) disable iff (!rstn) // R01
    interp_mode |-> burst_seen <= 5'h10)
    else $error("more than 16 microsteps in one burst");

  a_period_split: assert property (@(posedge clk) disable iff (!rstn) // R03
    step_edge && per_cnt[20:4] != 17'h0 |=> interval == $past(per_cnt[20:4]))
    else $error("spacing not period over 16");

  a_interval_cap: assert property (@(posedge clk) disable iff (!rstn) // R04
    interval <= 17'h10000 && per_cnt <= PERIOD_LIMIT)
    else $error("period or spacing above limit");

  a_stst_set: assert property (@(posedge clk) disable iff (!rstn) // R05
    per_cnt == PERIOD_LIMIT - 21'h1 && !step_edge |=> standstill)
    else $error("standstill not flagged at limit");

  a_hold_current: assert property (@(posedge clk) disable iff (!rstn) // R06
    standstill |-> current_level == hold_current_level)
    else $error("hold current not selected");

  a_stst_clear: assert property (@(posedge clk) disable iff (!rstn) // R07
    step_edge |=> !standstill)
    else $error("standstill not cleared by step edge");

  a_burst_abandon: assert property (@(posedge clk) disable iff (!rstn) // R09
    step_edge && interp_mode && burst_left != 5'h0 |=> burst_left == 5'hf && tick == 17'h0)
    else $error("running burst not restarted");

  a_ext_clock: assert property (@(posedge clk) disable iff (!rstn) // R12
    clkpin_s |=> clock_ext_sel [*3])
    else $error("external clock not kept selected");

  a_dir_count: assert property (@(posedge clk) disable iff (!rstn) // R17
    step_edge && !interp_mode && !dir_s |=> microstep_count == $past(microstep_count) + $past(step_width))
    else $error("direction low did not count up");

  a_micro_dir: assert property (@(posedge clk) disable iff (!rstn) // R18
    !step_edge && burst_left != 5'h0 && burst_dir && tick >= interval - 17'h1
    |=> microstep_count == $past(microstep_count) - 10'h1)
    else $error("microstep not one entry down");

endmodule : sis_interp

/* File: verification/sis_step_src.sv */
// Purpose: Step and direction source in place of the motion controller
// Assumes: Driven from the bench clock, one change per edge
// Notes: Direction is set one clock ahead of the step edge
`timescale 1ns/1ps
module sis_step_src
(
  // Clock
  input wire logic clk,
  // Pins towards the device
  output logic step_pin,
  output logic dir_pin
);
  // Idle levels
  initial
  begin
    step_pin = 1'b0;
    dir_pin = 1'b0;
  end

  // One pulse, high for hi clocks then low for lo clocks
  task automatic pulse(input logic d, input int hi, input int lo);
    @(posedge clk);
    dir_pin <= d;
    @(posedge clk);
    step_pin <= 1'b1;
    repeat (hi) @(posedge clk);
    step_pin <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask : pulse
endmodule : sis_step_src

/* File: verification/sis_interp_tb_top.sv */
// Purpose: Self-checking bench for the step interpolator
// Assumes: Step source model drives step and direction
// Notes: Standstill limit is shortened by parameter to fit the run
`timescale 1ns/1ps
module sis_interp_tb_top;
  import sis_pkg::*;
  typedef struct {logic [3:0] res; logic dir; logic de; logic ie; logic [9:0] d;} sis_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic step_pin;
  logic dir_pin;
  logic clk_pin = 1'b0;
  logic interp_enable = 1'b0;
  logic dedge = 1'b0;
  logic [3:0] resolution_select = 4'h0;
  logic [CUR_W-1:0] run_current_level = 5'h1f;
  logic [CUR_W-1:0] hold_current_level = 5'h05;
  logic short_detect_enable = 1'b0;
  logic short_detect_raw = 1'b0;
  logic short_detect_flag;
  logic [9:0] microstep_count;
  logic microstep_pulse;
  logic standstill;
  logic [CUR_W-1:0] current_level;
  logic interp_active;
  logic clock_ext_sel;
  logic [9:0] base;
  int n_errors = 0;
  int checks_done = 0;
  int n_pulse = 0;
  int mark;
  // Shortened period limit so that standstill is reached
  localparam logic [20:0] TEST_LIMIT = 21'h000400;
  sis_row_t rows [7] = '{'{4'h0, 1'b0, 1'b0, 1'b0, 10'h001}, '{4'h3, 1'b1, 1'b0, 1'b0, 10'h3f8},
    '{4'h8, 1'b0, 1'b0, 1'b0, 10'h100}, '{4'hb, 1'b1, 1'b0, 1'b0, 10'h300},
    '{4'h4, 1'b0, 1'b0, 1'b0, 10'h010}, '{4'h5, 1'b0, 1'b0, 1'b1, 10'h020},
    '{4'h0, 1'b0, 1'b1, 1'b0, 10'h002}};

  always #20 clk = ~clk;

  // Count microstep pulses
  always @(posedge clk)
    if (microstep_pulse === 1'b1)
      n_pulse <= n_pulse + 1;

  sis_step_src src (.clk(clk), .step_pin(step_pin), .dir_pin(dir_pin));

  sis_interp #(.PERIOD_LIMIT(TEST_LIMIT)) dut (.clk(clk), .rstn(rstn), .step_pin(step_pin), .dir_pin(dir_pin),
    .clk_pin(clk_pin),
    .interp_enable(interp_enable), .dedge(dedge), .resolution_select(resolution_select),
    .run_current_level(run_current_level), .hold_current_level(hold_current_level),
    .short_detect_enable(short_detect_enable), .short_detect_raw(short_detect_raw),
    .short_detect_flag(short_detect_flag), .microstep_count(microstep_count),
    .microstep_pulse(microstep_pulse), .standstill(standstill), .current_level(current_level),
    .interp_active(interp_active), .clock_ext_sel(clock_ext_sel));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and close
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Watchdog
  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    chk(16'(microstep_count), 16'h0);
    chk(16'(standstill), 16'h0);
    chk(16'(current_level), 16'h1f);
    rstn <= 1'b1;
    // Plain stepping table
    foreach (rows[i])
    begin
      resolution_select <= rows[i].res;
      dedge <= rows[i].de;
      interp_enable <= rows[i].ie;
      base = microstep_count;
      src.pulse(rows[i].dir, 3, 3);
      repeat (5) @(posedge clk);
      chk(16'(10'(microstep_count - base)), 16'(rows[i].d));
    end
    // Interpolated burst at a period of 329 clocks
    resolution_select <= RES_16X;
    interp_enable <= 1'b1;
    dedge <= 1'b0;
    src.pulse(1'b0, 3, 324);
    base = microstep_count;
    mark = n_pulse;
    src.pulse(1'b0, 3, 324);
    chk(16'(n_pulse - mark), 16'h10);
    chk(16'(10'(microstep_count - base)), 16'h10);
    chk(16'(interp_active), 16'h0);
    // Faster edge cuts a burst short, then the new rate
    base = microstep_count;
    mark = n_pulse;
    src.pulse(1'b1, 3, 150);
    src.pulse(1'b1, 3, 150);
    chk(16'(n_pulse - mark), 16'h18);
    chk(16'(10'(microstep_count - base)), 16'h3e8);
    chk(16'(current_level), 16'h1f);
    // Short detection gating
    for (int k = 0; k < 4; k++)
    begin
      short_detect_enable <= k[1];
      short_detect_raw <= k[0];
      @(posedge clk);
      chk(16'(short_detect_flag), 16'(k == 3));
    end
    // Clock pin selection is sticky
    chk(16'(clock_ext_sel), 16'h0);
    clk_pin <= 1'b1;
    repeat (4) @(posedge clk);
    // Motor idle before the clock pin stops
    chk(16'(interp_active), 16'h0);
    clk_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'(clock_ext_sel), 16'h1);
    // No step edge for longer than the limit, then one edge
    repeat (TEST_LIMIT + 21'h50) @(posedge clk);
    chk(16'(standstill), 16'h1);
    chk(16'(current_level), 16'h05);
    src.pulse(1'b0, 3, 3);
    chk(16'(standstill), 16'h0);
    chk(16'(current_level), 16'h1f);
    // Reset in mid-run restores defaults
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(16'(microstep_count), 16'h0);
    chk(16'(clock_ext_sel), 16'h0);
    chk(16'(interp_active), 16'h0);
    complete_run();
  end
endmodule : sis_interp_tb_top
